// file: verilog/pllmp_pkg.sv
`default_nettype none
package pllmp_pkg;

  // ************************************************************
  // Register map, I/O space, 16-bit words
  // ************************************************************
  localparam logic [15:0] MULT_OFFSET = 16'h1c88;
  localparam logic [15:0] PRESC_OFFSET = 16'h1c8a;
  localparam int DATA_W = 16;
  localparam int FIELD_W = 5;

  // ************************************************************
  // Field positions
  // ************************************************************
  localparam int FIELD_LSB = 0;
  localparam int FIELD_MSB = 4;
  localparam int PRESC_EN_BIT = 15;

  // ************************************************************
  // Values after reset and legal multiplier codes
  // ************************************************************
  localparam logic [4:0] MULT_RESET = 5'h00;
  localparam logic [4:0] RATIO_RESET = 5'h00;
  localparam logic PRESC_EN_RESET = 1'b1;
  localparam logic [4:0] MULT_MIN = 5'h02;
  localparam logic [4:0] MULT_MAX = 5'h0f;
  localparam logic [15:0] READ_ZERO = 16'h0000;

  // ************************************************************
  // Carriers
  // ************************************************************
  typedef struct packed {
    logic [15:0] addr;
    logic wr;
    logic rd;
    logic [15:0] wdata;
  } pllmp_io_req_type;

  typedef struct packed {
    logic [4:0] mult;
    logic mult_legal;
    logic loop_active;
    logic presc_tick;
    logic presc_en;
  } pllmp_loop_cfg_type;

endpackage : pllmp_pkg
`default_nettype wire

// file: verilog/pllmp_regs.sv
// What this block does
// - Multiplier field is bits 4:0; codes 2..15 multiply, others reserved.
// - Reserved bits read zero; writes to them change nothing.
// - Prescaler ratio field bits 4:0 sets reference pre-division.
// - Prescaler divides by ratio field plus one.
// - Ratio all ones divides by 32; no ratio code is reserved.
// - Prescaler enable is bit 15, read/write, resets to one.
// - Writing zero to the enable bit stops the prescaler.
// - Ratio and multiplier fields both reset to zero.
// - Locked loop frequency follows multiplier and ratio fields.
// - Loop mode enable cleared means bypass of the loop; the prescaler keeps ticking.
`timescale 1ns/1ps
`default_nettype none
module pllmp_regs #(
  parameter int RATIO_W = pllmp_pkg::FIELD_W
) (
  input wire logic CLK_SYS_I,
  input wire logic NRST_I,
  input wire pllmp_pkg::pllmp_io_req_type IO_REQ_I,
  input wire logic LOOP_MODE_ENABLE_I,
  output logic [15:0] IO_RDATA_O,
  output pllmp_pkg::pllmp_loop_cfg_type LOOP_CFG_O
);
  import pllmp_pkg::*;

  // ************************************************************
  // Parameter check
  // ************************************************************
  generate
    if (RATIO_W != FIELD_W) begin : g_bad_width
      $error("RATIO_W must equal the 5-bit ratio field");
    end
  endgenerate

  // ************************************************************
  // State
  // ************************************************************
  typedef struct packed {
    logic [4:0] mult;
    logic mult_legal;
    logic [4:0] ratio;
    logic presc_en;
    logic [4:0] cnt;
    logic tick;
    logic loop_active;
    logic [15:0] rdata;
  } pllmp_state_type;

  pllmp_state_type st;
  pllmp_state_type next_st;

  function automatic logic mult_is_legal(input logic [4:0] code);
    mult_is_legal = (code >= MULT_MIN) && (code <= MULT_MAX);
  endfunction : mult_is_legal

  function automatic logic [15:0] read_word(input logic [15:0] addr,
                                            input pllmp_state_type s);
    read_word = READ_ZERO;
    if (addr == MULT_OFFSET) begin
      read_word[FIELD_MSB:FIELD_LSB] = s.mult;
    end else if (addr == PRESC_OFFSET) begin
      read_word[FIELD_MSB:FIELD_LSB] = s.ratio;
      read_word[PRESC_EN_BIT] = s.presc_en;
    end
  endfunction : read_word

  wire logic hit_mult = IO_REQ_I.wr && (IO_REQ_I.addr == MULT_OFFSET);
  wire logic hit_presc = IO_REQ_I.wr && (IO_REQ_I.addr == PRESC_OFFSET);

  always_comb begin
    next_st = st;
    // Only the field bits are stored; reserved bits are dropped
    if (hit_mult) begin
      next_st.mult = IO_REQ_I.wdata[FIELD_MSB:FIELD_LSB];
    end
    // Reserved codes are flagged, never remapped, so software
    // sees what it wrote; the loop must not lock on them
    next_st.mult_legal = mult_is_legal(next_st.mult);
    if (hit_presc) begin
      next_st.ratio = IO_REQ_I.wdata[FIELD_MSB:FIELD_LSB];
      next_st.presc_en = IO_REQ_I.wdata[PRESC_EN_BIT];
    end
    // Divider runs on the stored ratio, so a new ratio takes effect
    // one cycle after the write; a shrink mid-count wraps at once
    if (!st.presc_en) begin
      next_st.cnt = 5'h00;
      next_st.tick = 1'b0;
    end else if (st.cnt >= st.ratio) begin
      next_st.cnt = 5'h00;
      next_st.tick = 1'b1;
    end else begin
      next_st.cnt = st.cnt + 5'h01;
      next_st.tick = 1'b0;
    end
    // Bypass: loop output not used, multiplier ignored downstream
    next_st.loop_active = LOOP_MODE_ENABLE_I;
    if (IO_REQ_I.rd) begin
      next_st.rdata = read_word(IO_REQ_I.addr, st);
    end
  end

  always_ff @(posedge CLK_SYS_I or negedge NRST_I) begin
    if (!NRST_I) begin
      st.mult <= MULT_RESET;
      st.mult_legal <= 1'b0;
      st.ratio <= RATIO_RESET;
      st.presc_en <= PRESC_EN_RESET;
      st.cnt <= 5'h00;
      st.tick <= 1'b0;
      st.loop_active <= 1'b0;
      st.rdata <= READ_ZERO;
    end else begin
      st <= next_st;
    end
  end

  // ************************************************************
  // Outputs, all from flip-flops
  // ************************************************************
  assign IO_RDATA_O = st.rdata;
  assign LOOP_CFG_O.mult = st.mult;
  assign LOOP_CFG_O.mult_legal = st.mult_legal;
  assign LOOP_CFG_O.loop_active = st.loop_active;
  assign LOOP_CFG_O.presc_tick = st.tick;
  assign LOOP_CFG_O.presc_en = st.presc_en;

  // ************************************************************
  // Assertions
  // ************************************************************
  default clocking cb @(posedge CLK_SYS_I); endclocking
  default disable iff (!NRST_I);

  mult_write_a: assert property (
    hit_mult |=> LOOP_CFG_O.mult == $past(IO_REQ_I.wdata[4:0]))
    else $error("multiplier field not written");

  legal_flag_a: assert property (
    ##1 LOOP_CFG_O.mult_legal ==
      (LOOP_CFG_O.mult >= 5'h02 && LOOP_CFG_O.mult <= 5'h0f))
    else $error("multiplier legal flag wrong");

  reserved_zero_a: assert property (
    IO_REQ_I.rd |=> IO_RDATA_O[14:5] == 10'h000)
    else $error("reserved bits read nonzero");

  read_back_a: assert property (
    (IO_REQ_I.rd && IO_REQ_I.addr == 16'h1c8a) |=>
      IO_RDATA_O == {$past(st.presc_en), 10'h000, $past(st.ratio)})
    else $error("prescaler read back wrong");

  tick_spacing_a: assert property (
    (LOOP_CFG_O.presc_tick && st.ratio == 5'h01 && st.presc_en &&
     !hit_presc) ##1 !hit_presc |=> LOOP_CFG_O.presc_tick)
    else $error("divide by two spacing wrong");

  div_one_a: assert property (
    (st.presc_en && st.ratio == 5'h00) |=> LOOP_CFG_O.presc_tick)
    else $error("divide by one misses ticks");

  div_max_a: assert property (
    (LOOP_CFG_O.presc_tick && st.ratio == 5'h1f && !hit_presc)
      ##1 (!hit_presc)[*8] |-> !LOOP_CFG_O.presc_tick)
    else $error("divide by 32 ticks early");

  disabled_a: assert property (
    (!st.presc_en ##1 !st.presc_en) |-> !LOOP_CFG_O.presc_tick)
    else $error("disabled prescaler ticks");

  bypass_a: assert property (
    !LOOP_MODE_ENABLE_I |=> !LOOP_CFG_O.loop_active)
    else $error("bypass not followed");

  reset_val_a: assert property (
    $rose(NRST_I) |-> LOOP_CFG_O.mult == 5'h00 && st.ratio == 5'h00)
    else $error("reset values wrong");

  ratio_write_a: assert property (
    hit_presc |=> st.ratio == $past(IO_REQ_I.wdata[4:0]))
    else $error("prescaler ratio not written");

  enable_write_a: assert property (
    hit_presc |=> LOOP_CFG_O.presc_en == $past(IO_REQ_I.wdata[15]))
    else $error("prescaler enable not written");

  mult_read_a: assert property (
    (IO_REQ_I.rd && IO_REQ_I.addr == 16'h1c88) |=>
      IO_RDATA_O == {11'h000, $past(st.mult)})
    else $error("multiplier read back wrong");

  unmapped_read_a: assert property (
    (IO_REQ_I.rd && IO_REQ_I.addr != 16'h1c88 &&
     IO_REQ_I.addr != 16'h1c8a) |=> IO_RDATA_O == 16'h0000)
    else $error("unmapped read nonzero");

  cfg_hold_a: assert property (
    !(hit_mult || hit_presc) |=> $stable(LOOP_CFG_O.mult) &&
      $stable(LOOP_CFG_O.presc_en))
    else $error("config changed without write");

  loop_follow_a: assert property (
    LOOP_MODE_ENABLE_I |=> LOOP_CFG_O.loop_active)
    else $error("loop mode not followed");

  tick_single_a: assert property (
    (LOOP_CFG_O.presc_tick && st.ratio != 5'h00) |=>
      !LOOP_CFG_O.presc_tick)
    else $error("prescaler tick longer than one cycle");

  div_three_a: assert property (
    (LOOP_CFG_O.presc_tick && st.ratio == 5'h02 && st.presc_en &&
     !hit_presc) ##1 !hit_presc ##1 !hit_presc |=> LOOP_CFG_O.presc_tick)
    else $error("divide by three spacing wrong");

  en_reset_a: assert property (
    $rose(NRST_I) |-> LOOP_CFG_O.presc_en)
    else $error("prescaler enable reset value wrong");

  disable_c: cover property (hit_presc && !IO_REQ_I.wdata[15]);
  max_div_c: cover property (st.ratio == 5'h1f && LOOP_CFG_O.presc_tick);
  legal_c: cover property (LOOP_CFG_O.mult_legal && st.loop_active);
  div_two_c: cover property (st.ratio == 5'h01 && LOOP_CFG_O.presc_tick);

endmodule : pllmp_regs
`default_nettype wire

// file: tb/pllmp_testbench.sv
`timescale 1ns/1ps
`default_nettype none
module testbench;
  import pllmp_pkg::*;
  logic clk_sys = 1'b0;
  logic nrst = 1'b0;
  pllmp_io_req_type io_req = '0;
  logic loop_mode_enable = 1'b0;
  logic [15:0] io_rdata;
  pllmp_loop_cfg_type loop_cfg;
  int failures = 0;
  int comparisons = 0;
  int ratios[3] = '{1, 4, 31};
  int ticks;

  always #10 clk_sys = ~clk_sys;

  pllmp_regs #(.RATIO_W(5)) u_dut (
    .CLK_SYS_I(clk_sys),
    .NRST_I(nrst),
    .IO_REQ_I(io_req),
    .LOOP_MODE_ENABLE_I(loop_mode_enable),
    .IO_RDATA_O(io_rdata),
    .LOOP_CFG_O(loop_cfg)
  );

  // ************************************************************
  // Access tasks
  // ************************************************************
  task automatic chk(input string what, input logic [15:0] exp,
                     input logic [15:0] got);
    comparisons++;
    if (got !== exp) begin
      failures++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask : chk

  task automatic wr(input logic [15:0] a, input logic [15:0] d);
    @(negedge clk_sys);
    io_req = '{addr: a, wr: 1'b1, rd: 1'b0, wdata: d};
    @(negedge clk_sys);
    io_req.wr = 1'b0;
    @(negedge clk_sys);
  endtask : wr

  task automatic chk_reg(input string what, input logic [15:0] a,
                         input logic [15:0] exp);
    @(negedge clk_sys);
    io_req.addr = a;
    io_req.rd = 1'b1;
    @(negedge clk_sys);
    io_req.rd = 1'b0;
    @(negedge clk_sys);
    chk(what, exp, io_rdata);
  endtask : chk_reg

  // Skips two ticks first so a wrap caused by the ratio change is not timed
  task automatic gap(input string what, input int n);
    int i;
    int c;
    i = 0;
    c = 1;
    repeat (2) begin
      while (loop_cfg.presc_tick !== 1'b1 && i < 100) begin
        @(negedge clk_sys);
        i++;
      end
      @(negedge clk_sys);
    end
    while (loop_cfg.presc_tick !== 1'b1 && c < 100) begin
      @(negedge clk_sys);
      c++;
    end
    chk(what, n[15:0], c[15:0]);
  endtask : gap

  task automatic give_verdict();
    $display("comparisons %0d failures %0d", comparisons, failures);
    if (failures == 0 && comparisons > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask : give_verdict

  // ************************************************************
  // Tests
  // ************************************************************
  initial begin
    repeat (16) @(negedge clk_sys);
    nrst = 1'b1;
    chk_reg("mult reset", MULT_OFFSET, 16'h0000);
    chk_reg("presc reset", PRESC_OFFSET, 16'h8000);
    chk("legal reset", 16'h0, {15'h0, loop_cfg.mult_legal});
    gap("ratio 0 gap", 1);
    $display("test reset done");
    for (int c = 0; c < 32; c++) begin
      wr(MULT_OFFSET, {11'h7ff, c[4:0]});
      chk("mult", {11'h0, c[4:0]}, {11'h0, loop_cfg.mult});
      chk("legal", (c > 1 && c < 16), {15'h0, loop_cfg.mult_legal});
    end
    chk_reg("mult reserved", MULT_OFFSET, 16'h001f);
    $display("test multiplier done");
    foreach (ratios[k]) begin
      wr(PRESC_OFFSET, {1'b1, 10'h3ff, ratios[k][4:0]});
      chk_reg("presc", PRESC_OFFSET, {11'h400, ratios[k][4:0]});
      gap("ratio gap", ratios[k] + 1);
    end
    $display("test ratio done");
    // Enable cleared must silence the tick entirely
    wr(PRESC_OFFSET, 16'h001f);
    chk("presc_en", 16'h0, {15'h0, loop_cfg.presc_en});
    ticks = 0;
    repeat (40) begin
      @(negedge clk_sys);
      if (loop_cfg.presc_tick !== 1'b0) ticks++;
    end
    chk("ticks off", 16'h0, ticks[15:0]);
    chk_reg("presc off", PRESC_OFFSET, 16'h001f);
    wr(PRESC_OFFSET, 16'h8002);
    gap("reenable gap", 3);
    $display("test enable done");
    chk_reg("unmapped", 16'h1c8c, 16'h0000);
    wr(16'h1c8c, 16'h0005);
    chk_reg("mult kept", MULT_OFFSET, 16'h001f);
    // Loop mode needs a legal multiplier first; the stored code is reserved
    wr(MULT_OFFSET, 16'h000a);
    chk("mult legal", 16'h1, {15'h0, loop_cfg.mult_legal});
    loop_mode_enable = 1'b1;
    @(negedge clk_sys);
    chk("loop on", 16'h1, {15'h0, loop_cfg.loop_active});
    loop_mode_enable = 1'b0;
    @(negedge clk_sys);
    chk("loop off", 16'h0, {15'h0, loop_cfg.loop_active});
    $display("test map and mode done");
    give_verdict();
  end

  initial begin
    #200us;
    failures++;
    $display("watchdog expired");
    give_verdict();
  end
endmodule : testbench
`default_nettype wire
